// >>> shared/dac_regs.svh
// register offsets, field positions, reset values and codes for dac
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH

// debug module interface offsets (word indices)
`define DAC_OFS_VALUE 7'h04
`define DAC_OFS_ADDR 7'h05
`define DAC_OFS_CS 7'h16
`define DAC_OFS_CMD 7'h17

// command word fields
`define DAC_TYPE_MSB 31
`define DAC_TYPE_LSB 24
`define DAC_SIZE_MSB 22
`define DAC_SIZE_LSB 20
`define DAC_WRITE_BIT 16
`define DAC_REGNO_MSB 15
`define DAC_REGNO_LSB 0

// control/status word fields
`define DAC_BUSY_BIT 12
`define DAC_CMDERR_MSB 10
`define DAC_CMDERR_LSB 8
`define DAC_DCOUNT_MSB 3
`define DAC_DCOUNT_LSB 0

// encodings
`define DAC_TYPE_REG 8'h00
`define DAC_TYPE_MEM 8'h02
`define DAC_SIZE_32 3'h2
`define DAC_ERR_NONE 3'h0
`define DAC_ERR_BUSY 3'h1
`define DAC_ERR_NOTSUP 3'h2
`define DAC_ERR_EXCEPT 3'h3
`define DAC_ERR_HALT 3'h4
`define DAC_ERR_OTHER 3'h7
`define DAC_GPR_LAST 16'h101f

// reset and fixed read values
`define DAC_ARG_RESET 32'h0000_0000
`define DAC_CMD_RESET 32'h0000_0000
`define DAC_DATACOUNT 4'h2
`define DAC_CMD_READ 32'h0022_0000
`define DAC_RD_NONE 32'h0000_0000

`endif

// >>> shared/dac_pkg.sv
// types shared by the abstract command block and its decoder
package dac_pkg;

	// one-hot execution states
	typedef enum logic [3:0] {
		DAC_IDLE  = 4'b0001,
		DAC_CHECK = 4'b0010,
		DAC_REG   = 4'b0100,
		DAC_MEM   = 4'b1000
	} dac_state_type;

	// one access on the debug module interface
	typedef struct packed {
		logic        valid;
		logic        wr;
		logic [6:0]  addr;
		logic [31:0] wdata;
	} dac_dmi_type;

	// request toward the core register file or local memories
	typedef struct packed {
		logic        valid;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dac_acc_type;

	// completion from the core side
	typedef struct packed {
		logic        done;
		logic        fault;
		logic [31:0] rdata;
	} dac_rsp_type;

	// result of decoding a command word
	typedef struct packed {
		logic       is_reg;
		logic [2:0] err;
	} dac_dec_type;

	// whole state of the command block
	typedef struct packed {
		dac_state_type st;
		logic [31:0]   value;
		logic [31:0]   addr;
		logic [31:0]   cmd;
		logic [2:0]    cmderr;
		logic [31:0]   rdata;
	} dac_all_type;

endpackage

// >>> hdl/dac_cmd_decode.sv
// decoder that checks a latched command word and classifies it
`timescale 1ns/1ps
`include "dac_regs.svh"

module dac_cmd_decode (
	input  wire logic [31:0]          cmd_word,
	input  wire logic                 hart_halted,
	output dac_pkg::dac_dec_type      dec
);

	logic [7:0]  cmd_type;
	logic [2:0]  cmd_size;
	logic [15:0] cmd_regno;

	// command fields
	assign cmd_type  = cmd_word[`DAC_TYPE_MSB:`DAC_TYPE_LSB];
	assign cmd_size  = cmd_word[`DAC_SIZE_MSB:`DAC_SIZE_LSB];
	assign cmd_regno = cmd_word[`DAC_REGNO_MSB:`DAC_REGNO_LSB];

	// first failing check wins; memory commands need no hart state
	always_comb
	begin
		dec.is_reg = (cmd_type == `DAC_TYPE_REG);
		dec.err    = `DAC_ERR_NONE;
		if (cmd_type != `DAC_TYPE_REG && cmd_type != `DAC_TYPE_MEM)
		begin
			dec.err = `DAC_ERR_NOTSUP;
		end
		else if (cmd_size != `DAC_SIZE_32)
		begin
			dec.err = `DAC_ERR_OTHER;
		end
		else if (dec.is_reg && cmd_regno > `DAC_GPR_LAST)
		begin
			dec.err = `DAC_ERR_NOTSUP;
		end
		else if (dec.is_reg && !hart_halted)
		begin
			dec.err = `DAC_ERR_HALT;
		end
	end

endmodule

// >>> hdl/dac_exec.sv
// abstract command execution: argument words, command decode, data moves
//
// Overview of operation
// - command top byte: 0 register access, 2 memory access, others unsupported
// - register command with size other than 2 fails with error 7
// - memory command with size other than 2 fails with error 7
// - register read copies selected register into the value word
// - register write copies the value word into selected register
// - numbers up to 0x0FFF are Control_status_registers, 0x1000-0x101F General_purpose_registers, rest unused
// - memory read loads word at address word into the value word
// - memory write stores value word at the address word
// - memory commands reach only local memories and interrupt controller
// - optional command fields read as fixed constants, reserved bits zero
// - value word carries input and result; address word gives address
// - exactly two argument words; count field reports 2
// - argument access while busy sets error 1 if error was 0
// - argument writes while busy leave stored values unchanged
// - argument words are 32-bit read/write, reset to zero
// - writing the command word starts the command
// - command writes are ignored while the error code is nonzero
// - busy sets on command write and clears when command completes
// - error codes 2 unsupported, 3 bad address, 4 wrong hart state
`timescale 1ns/1ps
`include "dac_regs.svh"

module dac_exec (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  dac_pkg::dac_dmi_type      dmi,
	output logic [31:0]               dmi_rdata,
	input  wire logic                 hart_halted,
	output dac_pkg::dac_acc_type      reg_acc,
	input  dac_pkg::dac_rsp_type      reg_rsp,
	output dac_pkg::dac_acc_type      mem_acc,
	input  dac_pkg::dac_rsp_type      mem_rsp
);

	dac_pkg::dac_all_type s_q;
	dac_pkg::dac_all_type s_d;
	dac_pkg::dac_dec_type dec;
	logic                 busy;
	logic                 arg_hit;
	logic [31:0]          cs_view;

	// a new error lands only on a clean code; the first cause is kept
	function automatic logic [2:0] set_err(
		input logic [2:0] cur,
		input logic [2:0] code
	);
		set_err = (cur == `DAC_ERR_NONE) ? code : cur;
	endfunction

	// checks on the stored command word
	dac_cmd_decode u_dec (
		.cmd_word    (s_q.cmd),
		.hart_halted (hart_halted),
		.dec         (dec)
	);

	// status view and address classification
	assign busy = (s_q.st != dac_pkg::DAC_IDLE);
	assign arg_hit = (dmi.addr == `DAC_OFS_VALUE) ||
		(dmi.addr == `DAC_OFS_ADDR);

	always_comb
	begin
		cs_view = `DAC_RD_NONE;
		cs_view[`DAC_BUSY_BIT] = busy;
		cs_view[`DAC_CMDERR_MSB:`DAC_CMDERR_LSB] = s_q.cmderr;
		cs_view[`DAC_DCOUNT_MSB:`DAC_DCOUNT_LSB] = `DAC_DATACOUNT;
	end

	// next state: bus access first, then execution; set_err keeps an error set by the bus in that cycle
	always_comb
	begin
		s_d = s_q;

		if (dmi.valid)
		begin
			// read data, captured for the next cycle
			if (!dmi.wr)
			begin
				unique case (dmi.addr)
					`DAC_OFS_VALUE: s_d.rdata = s_q.value;
					`DAC_OFS_ADDR:  s_d.rdata = s_q.addr;
					`DAC_OFS_CS:    s_d.rdata = cs_view;
					`DAC_OFS_CMD:   s_d.rdata = `DAC_CMD_READ;
					default:        s_d.rdata = `DAC_RD_NONE;
				endcase
			end

			// argument words: blocked while a command runs
			if (arg_hit && busy)
			begin
				s_d.cmderr = set_err(s_d.cmderr, `DAC_ERR_BUSY);
			end
			else if (arg_hit && dmi.wr)
			begin
				if (dmi.addr == `DAC_OFS_VALUE)
				begin
					s_d.value = dmi.wdata;
				end
				else
				begin
					s_d.addr = dmi.wdata;
				end
			end

			// control/status: error code is write-one-to-clear
			if (dmi.wr && dmi.addr == `DAC_OFS_CS)
			begin
				s_d.cmderr = s_q.cmderr &
					~dmi.wdata[`DAC_CMDERR_MSB:`DAC_CMDERR_LSB];
				if (busy)
				begin
					s_d.cmderr = set_err(s_d.cmderr, `DAC_ERR_BUSY);
				end
			end

			// command word: starts a command only when idle and clean
			if (dmi.wr && dmi.addr == `DAC_OFS_CMD)
			begin
				if (busy)
				begin
					s_d.cmderr = set_err(s_d.cmderr, `DAC_ERR_BUSY);
				end
				else if (s_q.cmderr == `DAC_ERR_NONE)
				begin
					s_d.cmd = dmi.wdata;
					s_d.st = dac_pkg::DAC_CHECK;
				end
			end
		end

		// execution sequence
		unique case (s_q.st)
			dac_pkg::DAC_IDLE:
			begin
				s_d.st = s_d.st;
			end
			dac_pkg::DAC_CHECK:
			begin
				// a failed check moves no data at all
				if (dec.err != `DAC_ERR_NONE)
				begin
					s_d.cmderr = set_err(s_d.cmderr, dec.err);
					s_d.st = dac_pkg::DAC_IDLE;
				end
				else if (dec.is_reg)
				begin
					s_d.st = dac_pkg::DAC_REG;
				end
				else
				begin
					s_d.st = dac_pkg::DAC_MEM;
				end
			end
			dac_pkg::DAC_REG:
			begin
				if (reg_rsp.done)
				begin
					if (reg_rsp.fault)
					begin
						s_d.cmderr = set_err(s_d.cmderr,
							`DAC_ERR_NOTSUP);
					end
					else if (!s_q.cmd[`DAC_WRITE_BIT])
					begin
						s_d.value = reg_rsp.rdata;
					end
					s_d.st = dac_pkg::DAC_IDLE;
				end
			end
			dac_pkg::DAC_MEM:
			begin
				if (mem_rsp.done)
				begin
					// address outside reachable ranges
					if (mem_rsp.fault)
					begin
						s_d.cmderr = set_err(s_d.cmderr,
							`DAC_ERR_EXCEPT);
					end
					else if (!s_q.cmd[`DAC_WRITE_BIT])
					begin
						s_d.value = mem_rsp.rdata;
					end
					s_d.st = dac_pkg::DAC_IDLE;
				end
			end
		endcase
	end

	// the whole state in one register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q.st     <= dac_pkg::DAC_IDLE;
			s_q.value  <= `DAC_ARG_RESET;
			s_q.addr   <= `DAC_ARG_RESET;
			s_q.cmd    <= `DAC_CMD_RESET;
			s_q.cmderr <= `DAC_ERR_NONE;
			s_q.rdata  <= `DAC_RD_NONE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// read data is held until the next read
	assign dmi_rdata = s_q.rdata;

	// register port: request stays up until the core reports done
	always_comb
	begin
		reg_acc.valid = (s_q.st == dac_pkg::DAC_REG);
		reg_acc.wr    = s_q.cmd[`DAC_WRITE_BIT];
		reg_acc.addr  = {16'h0000,
			s_q.cmd[`DAC_REGNO_MSB:`DAC_REGNO_LSB]};
		reg_acc.wdata = s_q.value;
	end

	// memory port: address word selects, value word carries data
	always_comb
	begin
		mem_acc.valid = (s_q.st == dac_pkg::DAC_MEM);
		mem_acc.wr    = s_q.cmd[`DAC_WRITE_BIT];
		mem_acc.addr  = s_q.addr;
		mem_acc.wdata = s_q.value;
	end

endmodule

// >>> testbench/dac_exec_checker.sv
// port checks on the abstract command block
`timescale 1ns/1ps
`include "dac_regs.svh"
module dac_exec_checker (
	input wire logic            mclk,
	input wire logic            rst_n,
	input dac_pkg::dac_dmi_type dmi,
	input wire logic [31:0]     dmi_rdata,
	input wire logic            hart_halted,
	input dac_pkg::dac_acc_type reg_acc,
	input dac_pkg::dac_rsp_type reg_rsp,
	input dac_pkg::dac_acc_type mem_acc,
	input dac_pkg::dac_rsp_type mem_rsp
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// decoded accesses; act skips the done cycle, busy drops right after
	wire logic rd_cs = dmi.valid && !dmi.wr && dmi.addr == `DAC_OFS_CS;
	wire logic rd_cmd = dmi.valid && !dmi.wr && dmi.addr == `DAC_OFS_CMD;
	wire logic cmd_wr = dmi.valid && dmi.wr && dmi.addr == `DAC_OFS_CMD;
	wire logic quiet = !reg_acc.valid && !mem_acc.valid;
	wire logic act = (reg_acc.valid && !reg_rsp.done)
		|| (mem_acc.valid && !mem_rsp.done);
	wire logic bad = dmi.wdata[31:24] != 8'h00 && dmi.wdata[31:24] != 8'h02;

	cnt_field_a: assert property (rd_cs |=> dmi_rdata[3:0] == 4'h2)
		else $error("count field wrong");
	cmd_fixed_a: assert property (rd_cmd |=> dmi_rdata == 32'h0022_0000)
		else $error("command read wrong");
	busy_show_a: assert property (rd_cs && act |=> dmi_rdata[12])
		else $error("busy not shown");
	reg_drop_a: assert property (reg_acc.valid && reg_rsp.done |=> !reg_acc.valid)
		else $error("register request held");
	mem_drop_a: assert property (mem_acc.valid && mem_rsp.done |=> !mem_acc.valid)
		else $error("memory request held");
	acc_hold_a: assert property (act |=> $stable(reg_acc) && $stable(mem_acc))
		else $error("request changed");
	one_path_a: assert property (!(reg_acc.valid && mem_acc.valid))
		else $error("both paths active");
	regno_ok_a: assert property (reg_acc.valid |-> reg_acc.addr <= 32'h0000_101f)
		else $error("register number out of range");
	bad_type_a: assert property (cmd_wr && bad && quiet && !$past(cmd_wr) |=> quiet[*2])
		else $error("unsupported command ran");
	// main scenarios reached
	cover property (reg_rsp.done);
	cover property (mem_rsp.done && mem_rsp.fault);
	cover property (rd_cs && act);
endmodule

// >>> testbench/dac_core_model.sv
// core register file and local memory answering the block
`timescale 1ns/1ps
module dac_core_model (
	input wire logic             mclk,
	input wire logic             rst_n,
	input wire logic [3:0]       delay,
	input dac_pkg::dac_acc_type  reg_acc,
	output dac_pkg::dac_rsp_type reg_rsp,
	input dac_pkg::dac_acc_type  mem_acc,
	output dac_pkg::dac_rsp_type mem_rsp
);
	logic [31:0]          store [64];
	logic [3:0]           wait_q;
	logic [5:0]           idx;
	dac_pkg::dac_acc_type acc;
	// registers and memory share one array, split by the top index bit
	assign acc = reg_acc.valid ? reg_acc : mem_acc;
	assign idx = {reg_acc.valid, acc.addr[6:2]};
	// one answer per request; data off the answer cycle keeps toggling
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_q <= 4'h0;
			reg_rsp <= '0;
			mem_rsp <= '0;
		end
		else
		begin
			reg_rsp <= '{1'b0, 1'b0, ~reg_rsp.rdata};
			mem_rsp <= '{1'b0, 1'b0, ~mem_rsp.rdata};
			wait_q <= acc.valid ? wait_q + 4'h1 : 4'h0;
			if (acc.valid && !reg_rsp.done && !mem_rsp.done && wait_q >= delay)
			begin
				wait_q <= 4'h0;
				if (acc.wr && !acc.addr[31])
					store[idx] <= acc.wdata;
				if (reg_acc.valid)
					reg_rsp <= '{1'b1, 1'b0, store[idx]};
				else
					mem_rsp <= '{1'b1, acc.addr[31], store[idx]};
			end
		end
	end
endmodule

// >>> testbench/tb_dac_exec.sv
// self-checking bench for the abstract command block
`timescale 1ns/1ps
`include "dac_regs.svh"
module tb_dac_exec;
	logic                 mclk;
	logic                 rst_n;
	logic                 hart_halted;
	logic                 note;
	logic                 seen;
	logic [3:0]           dly;
	logic [31:0]          dmi_rdata;
	logic [31:0]          v;
	logic [31:0]          a;
	logic [31:0]          q [$];
	integer               seed;
	int                   mismatches;
	int                   check_count;
	int                   k;
	dac_pkg::dac_dmi_type dmi;
	dac_pkg::dac_acc_type reg_acc;
	dac_pkg::dac_acc_type mem_acc;
	dac_pkg::dac_rsp_type reg_rsp;
	dac_pkg::dac_rsp_type mem_rsp;
	logic [31:0]          ec [6] = '{32'h0122_0000, 32'h0032_1000,
		32'h0212_0000, 32'h0022_1020, 32'h0221_0000, 32'h0022_1001};
	logic [2:0]           ee [6] = '{3'h2, 3'h7, 3'h7, 3'h2, 3'h3, 3'h4};

	dac_exec dut_u (.mclk(mclk), .rst_n(rst_n), .dmi(dmi),
		.dmi_rdata(dmi_rdata), .hart_halted(hart_halted),
		.reg_acc(reg_acc), .reg_rsp(reg_rsp),
		.mem_acc(mem_acc), .mem_rsp(mem_rsp));
	dac_core_model model_u (.mclk(mclk), .rst_n(rst_n), .delay(dly),
		.reg_acc(reg_acc), .reg_rsp(reg_rsp),
		.mem_acc(mem_acc), .mem_rsp(mem_rsp));

	always #20 mclk = ~mclk;

	task stop_test;
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [6:0] ad, input logic [31:0] d);
		@(posedge mclk);
		dmi <= '{1'b1, 1'b1, ad, d};
		note <= 1'b0;
		@(posedge mclk);
		dmi.valid <= 1'b0;
	endtask

	// noted reads are judged by the watcher one cycle later
	task automatic rd(input logic [6:0] ad, input logic [31:0] e, input logic c);
		@(posedge mclk);
		dmi <= '{1'b1, 1'b0, ad, 32'h0000_0000};
		note <= c;
		if (c)
			q.push_back(e);
		@(posedge mclk);
		dmi.valid <= 1'b0;
	endtask

	// poll busy under a bound
	task automatic idle;
		logic b;
		b = 1'b1;
		for (int i = 0; i < 40 && b; i++)
		begin
			rd(`DAC_OFS_CS, 32'h0000_0000, 1'b0);
			@(negedge mclk);
			b = dmi_rdata[12];
		end
		if (b !== 1'b0)
		begin
			mismatches++;
			stop_test;
		end
	endtask

	// watcher: a read taken at one edge is settled by the next negedge
	always @(posedge mclk)
		seen <= dmi.valid && !dmi.wr && note;
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected dmi_rdata exp %h seen %h", e, s);
		end
	endtask

	// own copy of the note, so the stimulus variables stay untouched
	always @(negedge mclk)
		if (seen)
			check(dmi_rdata, q.pop_front());

	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		stop_test;
	end

	initial
	begin
		seed = 32'h6cb8_26fc;
		mclk = 1'b0;
		rst_n = 1'b0;
		dmi = '0;
		note = 1'b0;
		seen = 1'b0;
		hart_halted = 1'b1;
		dly = 4'h0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`DAC_OFS_VALUE, 32'h0000_0000, 1'b1);
		rd(`DAC_OFS_ADDR, 32'h0000_0000, 1'b1);
		rd(`DAC_OFS_CS, 32'h0000_0002, 1'b1);
		rd(`DAC_OFS_CMD, 32'h0022_0000, 1'b1);
		// write then read back, register path on odd passes
		for (k = 0; k < 4; k++)
		begin
			v = $random(seed);
			a = {24'h00_0000, k[5:0], 2'b00};
			dly <= v[3:0];
			wr(`DAC_OFS_ADDR, a);
			wr(`DAC_OFS_VALUE, v);
			rd(`DAC_OFS_ADDR, a, 1'b1);
			wr(`DAC_OFS_CMD, k[0] ? 32'h0023_1005 : 32'h0221_0000);
			idle;
			wr(`DAC_OFS_VALUE, ~v);
			wr(`DAC_OFS_CMD, k[0] ? 32'h0022_1005 : 32'h0220_0000);
			idle;
			rd(`DAC_OFS_VALUE, v, 1'b1);
		end
		// argument access during a slow command
		dly <= 4'hf;
		wr(`DAC_OFS_CMD, 32'h0022_1005);
		wr(`DAC_OFS_ADDR, 32'h0000_0055);
		rd(`DAC_OFS_ADDR, 32'h0000_000c, 1'b1);
		idle;
		rd(`DAC_OFS_CS, 32'h0000_0102, 1'b1);
		wr(`DAC_OFS_CS, 32'h0000_0700);
		// failing commands; a later command must not start
		for (k = 0; k < 6; k++)
		begin
			hart_halted <= (k != 5);
			wr(`DAC_OFS_ADDR, 32'h8000_0000);
			wr(`DAC_OFS_CMD, ec[k]);
			idle;
			wr(`DAC_OFS_CMD, 32'h0022_1005);
			rd(`DAC_OFS_CS, {21'h0, ee[k], 8'h02}, 1'b1);
			wr(`DAC_OFS_CS, 32'h0000_0700);
		end
		rd(`DAC_OFS_CS, 32'h0000_0002, 1'b1);
		repeat (2) @(negedge mclk);
		if (q.size() != 0)
			mismatches++;
		stop_test;
	end
endmodule

bind dac_exec dac_exec_checker chk_u (.mclk(mclk), .rst_n(rst_n),
	.dmi(dmi), .dmi_rdata(dmi_rdata), .hart_halted(hart_halted),
	.reg_acc(reg_acc), .reg_rsp(reg_rsp),
	.mem_acc(mem_acc), .mem_rsp(mem_rsp));
